// ### rtl/csc_clock_ctrl.sv
// clock source decode, start-up sequencing and clock domain gating
`timescale 1ns/10ps
module csc_clock_ctrl
   import csc_pkg::*;
#(
   parameter int WdtLongCyc = WDT_LONG_CYC,
   parameter int Ck16k      = CK_16K,
   parameter int Ck32k      = CK_32K
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // wishbone slave
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // fuse pins
   input  wire logic [3:0]  clockSourceSelectFuses,
   input  wire logic [1:0]  startupTimeFuses,
   // oscillator ticks from outside this clock domain
   input  wire logic        watchdogOscillatorPin,
   input  wire logic        sourceClockPin,
   // wake sources and data write status
   input  wire logic        asyncIntPin,
   input  wire logic        twoWireAddrMatchPin,
   input  wire logic        wakeRequest,
   input  wire logic        nvWriteActive,
   // domain clock enables and status
   output logic             coreClockEn,
   output logic             peripheralClockEn,
   output logic             programMemoryClockEn,
   output logic             asyncTimerClockEn,
   output logic             converterClockEn,
   output logic             oscillatorRunEn,
   output logic             cpuRun
);
   localparam logic [16:0] WdtLong = 17'(WdtLongCyc);
   localparam logic [16:0] K16     = 17'(Ck16k);
   localparam logic [16:0] K32     = 17'(Ck32k);

   csc_state_t    state_q;
   csc_sleep_t    sleepMode_q;
   csc_src_t      srcKind;
   logic [3:0]    srcSel_q;
   logic [1:0]    sut_q;
   logic          sleepEn_q, oscHeld_q, rstDone_q, ack_q;
   logic [1:0]    settle_q;
   logic [16:0]   cnt_q, wdtTarget, startTarget;
   logic [2:0]    wdtSync_q, srcSync_q;
   logic [1:0]    intSync_q, twiSync_q, selSync_q[6];
   logic          wdtEdge, srcEdge, wakeSeen, wbReq, goWr;
   logic [31:0]   rdData;
   logic [5:0]    fusePins;

   // fuse pins as one vector so each bit gets its own two-stage synchroniser
   assign fusePins = {startupTimeFuses, clockSourceSelectFuses};

   // first stage feeds only the second; edge taken between stages two and three
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdtSync_q <= 3'h0;
         srcSync_q <= 3'h0;
         intSync_q <= 2'h0;
         twiSync_q <= 2'h0;
      end else begin
         wdtSync_q <= {wdtSync_q[1:0], watchdogOscillatorPin};
         srcSync_q <= {srcSync_q[1:0], sourceClockPin};
         intSync_q <= {intSync_q[0], asyncIntPin};
         twiSync_q <= {twiSync_q[0], twoWireAddrMatchPin};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_fuse_sync
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) selSync_q[gi] <= 2'h0;
            else selSync_q[gi] <= {selSync_q[gi][0], fusePins[gi]};
         end
      end
   endgenerate

   assign wdtEdge  = wdtSync_q[1] & ~wdtSync_q[2];
   assign srcEdge  = srcSync_q[1] & ~srcSync_q[2];
   // asynchronous wake paths work while the peripheral clock is stopped
   assign wakeSeen = intSync_q[1] | twiSync_q[1] | wakeRequest;

   // one = unprogrammed; the ranges are compared on the raw bit values
   always_comb begin
      if (srcSel_q >= SEL_XTAL_LO)       srcKind = SRC_XTAL;
      else if (srcSel_q == SEL_LFXTAL)   srcKind = SRC_LFXTAL;
      else if (srcSel_q >= SEL_RC_LO)    srcKind = SRC_EXTRC;
      else if (srcSel_q >= SEL_INTRC_LO) srcKind = SRC_INTRC;
      else                               srcKind = SRC_EXTCLK;
   end

   // reset delay; zero means none (brown-out options)
   always_comb begin
      wdtTarget = WdtLong;
      unique case (srcKind)
         SRC_XTAL: begin
            unique case ({srcSel_q[0], sut_q})
               3'h0, 3'h3, 3'h6: wdtTarget = WDT_SHORT_CYC;
               3'h2, 3'h5:       wdtTarget = 17'h0;
               default:          wdtTarget = WdtLong;
            endcase
         end
         SRC_LFXTAL: wdtTarget = (sut_q == 2'h0) ? WDT_SHORT_CYC : WdtLong;
         default: begin
            unique case (sut_q)
               2'h0:    wdtTarget = 17'h0;
               2'h1:    wdtTarget = WDT_SHORT_CYC;
               default: wdtTarget = WdtLong;
            endcase
         end
      endcase
   end

   always_comb begin
      startTarget = CK_OTHER;
      unique case (srcKind)
         SRC_XTAL: begin
            if (!srcSel_q[0]) startTarget = sut_q[1] ? CK_1K : CK_258;
            else              startTarget = (sut_q == 2'h0) ? CK_1K : K16;
         end
         SRC_LFXTAL: startTarget = (sut_q[1]) ? K32 : CK_1K;
         default:    startTarget = CK_OTHER;
      endcase
   end

   // fuses are latched once, after the synchronisers have settled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         srcSel_q <= SRC_SEL_DFLT;
         sut_q    <= SUT_DFLT;
      end else if (state_q == ST_FUSE && settle_q == FUSE_SETTLE) begin
         srcSel_q <= {selSync_q[3][1], selSync_q[2][1], selSync_q[1][1], selSync_q[0][1]};
         sut_q    <= {selSync_q[5][1], selSync_q[4][1]};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) settle_q <= 2'h0;
      else if (state_q == ST_FUSE && settle_q != FUSE_SETTLE) settle_q <= settle_q + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_FUSE;
         cnt_q   <= 17'h0;
      end else begin
         unique case (state_q)
            ST_FUSE: if (settle_q == FUSE_SETTLE) begin
               state_q <= ST_RST_DLY;
               cnt_q   <= 17'h0;
            end
            ST_RST_DLY: begin
               if (cnt_q >= wdtTarget) begin
                  state_q <= ST_START_CNT;
                  cnt_q   <= 17'h0;
               end else if (wdtEdge) cnt_q <= cnt_q + 17'h1;
            end
            ST_START_CNT, ST_WAKE_CNT: begin
               if (cnt_q >= startTarget) state_q <= ST_RUN;
               else if (srcEdge) cnt_q <= cnt_q + 17'h1;
            end
            ST_RUN: if (goWr && sleepEn_q) state_q <= ST_SLEEP;
            ST_SLEEP: if (wakeSeen) begin
               cnt_q   <= 17'h0;
               // only the modes that stop the oscillator need it to restart
               state_q <= (sleepMode_q == SLP_PWR_DOWN || sleepMode_q == SLP_PWR_SAVE)
                          ? ST_WAKE_CNT : ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rstDone_q <= 1'b0;
      else if (state_q == ST_RUN) rstDone_q <= 1'b1;
   end

   // a write running during power-down keeps the oscillator up from the next cycle until wake
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) oscHeld_q <= 1'b0;
      else if (state_q != ST_SLEEP) oscHeld_q <= 1'b0;
      else if (nvWriteActive && sleepMode_q == SLP_PWR_DOWN) oscHeld_q <= 1'b1;
   end

   always_comb begin
      coreClockEn       = (state_q == ST_RUN);
      peripheralClockEn = (state_q == ST_RUN);
      asyncTimerClockEn = 1'b1;
      converterClockEn  = (state_q == ST_RUN);
      oscillatorRunEn   = 1'b1;
      if (state_q == ST_SLEEP) begin
         unique case (sleepMode_q)
            SLP_IDLE: begin
               peripheralClockEn = 1'b1;
               converterClockEn  = 1'b1;
            end
            SLP_CONV_NOISE: converterClockEn = 1'b1;
            SLP_PWR_DOWN: begin
               asyncTimerClockEn = 1'b0;
               oscillatorRunEn   = oscHeld_q;
            end
            SLP_PWR_SAVE: oscillatorRunEn = 1'b0;
            SLP_STANDBY:  asyncTimerClockEn = 1'b0;
            default:      asyncTimerClockEn = 1'b1;
         endcase
      end
      programMemoryClockEn = coreClockEn;
   end

   assign cpuRun = (state_q == ST_RUN);

   // wishbone slave, one wait state
   assign wbReq = cyc_i & stb_i & ~ack_q;
   assign goWr  = wbReq & we_i & sel_i[0] & (adr_i == ADDR_CTRL) & dat_i[CTRL_SLEEP_GO];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleepMode_q <= csc_sleep_t'(CTRL_MODE_RST);
         sleepEn_q   <= 1'b0;
      end else if (wbReq && we_i && sel_i[0] && adr_i == ADDR_CTRL) begin
         sleepMode_q <= (dat_i[CTRL_MODE_LSB +: 3] > 3'h5) ? SLP_IDLE
                        : csc_sleep_t'(dat_i[CTRL_MODE_LSB +: 3]);
         sleepEn_q   <= dat_i[CTRL_SLEEP_EN];
      end
   end

   always_comb begin
      rdData = 32'h0;
      unique case (adr_i)
         ADDR_CTRL: begin
            rdData[CTRL_MODE_LSB +: 3] = sleepMode_q;
            rdData[CTRL_SLEEP_EN]      = sleepEn_q;
         end
         ADDR_STATUS: begin
            rdData[STAT_RUN]           = cpuRun;
            rdData[STAT_OSC_HELD]      = oscHeld_q;
            rdData[STAT_RST_DONE]      = rstDone_q;
            rdData[STAT_CLK_LSB +: 6]  = {oscillatorRunEn, converterClockEn, asyncTimerClockEn,
                                          programMemoryClockEn, peripheralClockEn, coreClockEn};
         end
         ADDR_FUSE: begin
            rdData[3:0]                = srcSel_q;
            rdData[FUSE_SUT_LSB +: 2]  = sut_q;
            rdData[FUSE_KIND_LSB +: 3] = srcKind;
         end
         default: rdData = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_q <= wbReq;
         if (wbReq) dat_o <= rdData;
      end
   end
   assign ack_o = ack_q;

   // checks
   sequence seq_wb_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence seq_wb_ack;
      ack_o ##1 !ack_o;
   endsequence
   sequence seq_wake_pd;
      state_q == ST_SLEEP && sleepMode_q == SLP_PWR_DOWN && wakeSeen;
   endsequence

   chk_wb_answer: assert property (@(posedge clk) disable iff (!rst_b)
      seq_wb_req |=> seq_wb_ack) else $error("wishbone ack not one cycle after request");
   chk_core_progmem: assert property (@(posedge clk) disable iff (!rst_b)
      coreClockEn == programMemoryClockEn && coreClockEn == cpuRun)
      else $error("core and program-memory clocks disagree");
   chk_periph_stop: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_SLEEP && sleepMode_q != SLP_IDLE |-> !peripheralClockEn)
      else $error("peripheral clock runs in deep sleep");
   chk_conv_noise: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_SLEEP && sleepMode_q == SLP_CONV_NOISE |-> converterClockEn && !coreClockEn)
      else $error("converter clock wrong in noise mode");
   chk_async_save: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_SLEEP && sleepMode_q == SLP_PWR_SAVE |-> asyncTimerClockEn && !oscillatorRunEn)
      else $error("async timer clock stopped in power-save");
   chk_osc_nvwrite: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_SLEEP && sleepMode_q == SLP_PWR_DOWN && nvWriteActive |=>
      state_q != ST_SLEEP || oscillatorRunEn) else $error("oscillator stopped during data write");
   chk_wake_count: assert property (@(posedge clk) disable iff (!rst_b)
      seq_wake_pd |=> (state_q == ST_WAKE_CNT && !cpuRun) [*2])
      else $error("power-down wake skipped start-up count");
   chk_reset_tick: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == ST_RST_DLY && $past(state_q) == ST_RST_DLY && !$past(wdtEdge) |-> $stable(cnt_q))
      else $error("reset delay counted without watchdog tick");
   chk_run_order: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cpuRun) |-> $past(state_q) == ST_START_CNT || $past(state_q) == ST_WAKE_CNT
      || $past(state_q) == ST_SLEEP) else $error("execution started out of sequence");
endmodule : csc_clock_ctrl

// ### rtl/csc_pkg.sv
// constants and types for the clock source and start-up controller
package csc_pkg;
   // register map, byte addresses on the wishbone bus
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_FUSE     = 8'h08;
   // control register fields
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_SLEEP_EN = 3;
   localparam int          CTRL_SLEEP_GO = 4;
   localparam logic [2:0]  CTRL_MODE_RST = 3'h0;
   // status register fields
   localparam int          STAT_RUN      = 0;
   localparam int          STAT_OSC_HELD = 1;
   localparam int          STAT_RST_DONE = 2;
   localparam int          STAT_CLK_LSB  = 4;
   // fuse register fields
   localparam int          FUSE_SUT_LSB  = 4;
   localparam int          FUSE_KIND_LSB = 6;
   // factory fuse values, read before the pins are sampled
   localparam logic [3:0]  SRC_SEL_DFLT  = 4'h1;
   localparam logic [1:0]  SUT_DFLT      = 2'h2;
   // source-select field boundaries
   localparam logic [3:0]  SEL_XTAL_LO   = 4'ha;
   localparam logic [3:0]  SEL_LFXTAL    = 4'h9;
   localparam logic [3:0]  SEL_RC_LO     = 4'h5;
   localparam logic [3:0]  SEL_INTRC_LO  = 4'h1;
   // counts
   localparam int          CNT_W         = 17;
   localparam logic [16:0] WDT_SHORT_CYC = 17'h01000;
   localparam int          WDT_LONG_CYC  = 65536;
   localparam logic [16:0] CK_258        = 17'h00102;
   localparam logic [16:0] CK_1K         = 17'h00400;
   localparam int          CK_16K        = 16384;
   localparam int          CK_32K        = 32768;
   localparam logic [16:0] CK_OTHER      = 17'h00006;
   localparam logic [1:0]  FUSE_SETTLE   = 2'h3;

   typedef enum logic [2:0] {
      SRC_XTAL, SRC_LFXTAL, SRC_EXTRC, SRC_INTRC, SRC_EXTCLK
   } csc_src_t;

   typedef enum logic [2:0] {
      SLP_IDLE, SLP_CONV_NOISE, SLP_PWR_DOWN, SLP_PWR_SAVE, SLP_STANDBY, SLP_EXT_STANDBY
   } csc_sleep_t;

   typedef enum logic [2:0] {
      ST_FUSE, ST_RST_DLY, ST_START_CNT, ST_RUN, ST_SLEEP, ST_WAKE_CNT
   } csc_state_t;
endpackage : csc_pkg

// ### dv/csc_osc_model.sv
// oscillator sources seen from the controller: watchdog and selected source clock
`timescale 1ns/10ps
module csc_osc_model #(
   parameter realtime WdtHalf = 8.3,
   parameter realtime SrcHalf = 6.1
) (
   // oscillator outputs
   output logic      wdtOsc,
   output logic      srcOsc,
   // oscillator run controls
   input  wire logic oscRun,
   input  wire logic wakeAny
);
   // watchdog oscillator runs free and unrelated in phase to the bus clock
   initial begin
      wdtOsc = 1'b0;
      forever #(WdtHalf) wdtOsc = ~wdtOsc;
   end

   // source stands still low while stopped; a wake restarts it, like a real crystal
   initial begin
      srcOsc = 1'b0;
      forever begin
         #(SrcHalf);
         if (oscRun || wakeAny) srcOsc = ~srcOsc;
         else srcOsc = 1'b0;
      end
   end
endmodule : csc_osc_model

// ### dv/testbench.sv
// self-checking bench for the clock source and start-up controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin nErrors++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
   import csc_pkg::*;
   localparam real WP = 16.6;
   localparam real SP = 12.2;
   logic        clk      = 1'b0;
   logic        rstB     = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [31:0] wdat     = 32'h0;
   logic [3:0]  sel      = 4'h0;
   logic        we       = 1'b0;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic [3:0]  fuseSel  = 4'hf;
   logic [1:0]  fuseSut  = 2'h3;
   logic        asyncInt = 1'b0;
   logic        twoWire  = 1'b0;
   logic        wakeReq  = 1'b0;
   logic        nvWrite  = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        wdtOsc, srcOsc, coreEn, periphEn, progEn, asyncEn, convEn, oscEn, cpuRun;
   logic [31:0] r;
   int          nErrors     = 0;
   int          totalChecks = 0;
   int          cycles      = 0;
   real         t0;

   always #2 clk = ~clk;

   csc_clock_ctrl #(.WdtLongCyc(64), .Ck16k(16), .Ck32k(32)) dut (
      .clk(clk), .rst_b(rstB), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc),
      .stb_i(stb), .dat_o(rdat), .ack_o(ack), .clockSourceSelectFuses(fuseSel),
      .startupTimeFuses(fuseSut), .watchdogOscillatorPin(wdtOsc), .sourceClockPin(srcOsc),
      .asyncIntPin(asyncInt), .twoWireAddrMatchPin(twoWire), .wakeRequest(wakeReq),
      .nvWriteActive(nvWrite), .coreClockEn(coreEn), .peripheralClockEn(periphEn),
      .programMemoryClockEn(progEn), .asyncTimerClockEn(asyncEn), .converterClockEn(convEn),
      .oscillatorRunEn(oscEn), .cpuRun(cpuRun));

   csc_osc_model osc (
      .wdtOsc(wdtOsc), .srcOsc(srcOsc), .oscRun(oscEn), .wakeAny(asyncInt | twoWire | wakeReq));

   task automatic finish_test();
      if (nErrors == 0 && totalChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      // only the bench timeout ends a wait that never sees ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   task automatic wait_run(output real t);
      int n = 0;
      while (cpuRun !== 1'b1 && n < 30000) begin
         @(posedge clk);
         n++;
      end
      t = $realtime - t0;
   endtask : wait_run

   // reset with given fuses; w watchdog cycles then n source cycles expected
   task automatic run_reset(input logic [3:0] s, input logic [1:0] u, input logic [2:0] k, input int w,
                            input int n);
      real t;
      real lo;
      lo = (w > 0 ? w - 1 : 0) * WP + (n - 1) * SP;
      @(posedge clk);
      rstB    <= 1'b0;
      fuseSel <= s;
      fuseSut <= u;
      repeat (6) @(posedge clk);
      rstB <= 1'b1;
      t0 = $realtime;
      wb(1'b0, ADDR_FUSE, 32'h0, 4'hf);
      `CHK("fuseEarly", {23'h0, 3'h3, SUT_DFLT, SRC_SEL_DFLT}, r)
      wait_run(t);
      `CHK("startDelay", 1'b1, t >= lo && t <= lo + 3 * WP + 3 * SP + 60.0)
      wb(1'b0, ADDR_FUSE, 32'h0, 4'hf);
      `CHK("fuseDecode", {23'h0, k, u, s}, r)
      wb(1'b1, ADDR_STATUS, 32'h0, 4'hf);
      wb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
      `CHK("statusRun", 32'h3f5, r)
   endtask : run_reset

   // enter sleep mode m, check gated domains, wake by source src
   task automatic sleep_case(input logic [2:0] m, input logic nv, input int src, input logic [4:0] exp5,
                             input int expOsc, input logic counted);
      real t;
      @(posedge clk);
      nvWrite <= nv;
      wb(1'b1, ADDR_CTRL, {29'h0, m} | 32'h8, 4'h1);
      wb(1'b1, ADDR_CTRL, {29'h0, m} | 32'h18, 4'h1);
      wb(1'b0, ADDR_CTRL, 32'h0, 4'hf);
      `CHK("ctrlRead", {29'h0, m} | 32'h8, r)
      repeat (2) @(posedge clk);
      `CHK("cpuHalted", 1'b0, cpuRun)
      `CHK("domainEn", exp5, {convEn, asyncEn, progEn, periphEn, coreEn})
      if (expOsc >= 0) `CHK("oscEn", expOsc[0], oscEn)
      if (nv) begin
         wb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
         `CHK("oscHeld", 1'b1, r[STAT_OSC_HELD])
      end
      @(posedge clk);
      wakeReq  <= (src == 0);
      asyncInt <= (src == 1);
      twoWire  <= (src == 2);
      t0 = $realtime;
      wait_run(t);
      if (counted) `CHK("wakeCount", 1'b1, t >= 15 * SP && t < 20 * SP + 100.0)
      else `CHK("wakeFast", 1'b1, t <= 40.0)
      wakeReq  <= 1'b0;
      asyncInt <= 1'b0;
      twoWire  <= 1'b0;
      nvWrite  <= 1'b0;
   endtask : sleep_case

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         nErrors++;
         finish_test();
      end
   end

   initial begin
      run_reset(4'hf, 2'h3, 3'h0, 64, 16);
      run_reset(4'he, 2'h0, 3'h0, 4096, 258);
      run_reset(4'he, 2'h2, 3'h0, 0, 1024);
      run_reset(4'h9, 2'h2, 3'h1, 64, 32);
      run_reset(4'h8, 2'h3, 3'h2, 64, 6);
      run_reset(4'h5, 2'h0, 3'h2, 0, 6);
      run_reset(4'h4, 2'h0, 3'h3, 0, 6);
      run_reset(4'h1, 2'h2, 3'h3, 64, 6);
      run_reset(4'h0, 2'h0, 3'h4, 0, 6);
      run_reset(4'hb, 2'h1, 3'h0, 0, 16);
      sleep_case(3'h0, 1'b0, 1, 5'b11010, -1, 1'b0);
      sleep_case(3'h1, 1'b0, 0, 5'b11000, -1, 1'b0);
      sleep_case(3'h2, 1'b0, 2, 5'b00000, 0, 1'b1);
      sleep_case(3'h2, 1'b1, 0, 5'b00000, 1, 1'b1);
      sleep_case(3'h3, 1'b0, 1, 5'b01000, 0, 1'b1);
      sleep_case(3'h4, 1'b0, 2, 5'b00000, 1, 1'b0);
      sleep_case(3'h5, 1'b0, 0, 5'b01000, 1, 1'b0);
      wb(1'b1, ADDR_CTRL, 32'h7, 4'h1);
      wb(1'b0, ADDR_CTRL, 32'h0, 4'hf);
      `CHK("ctrlBadMode", 32'h0, r)
      wb(1'b1, ADDR_CTRL, 32'h0a, 4'h0);
      wb(1'b0, ADDR_CTRL, 32'h0, 4'hf);
      `CHK("ctrlNoLane", 32'h0, r)
      wb(1'b0, 8'h0c, 32'h0, 4'hf);
      `CHK("unmapped", 32'h0, r)
      // go without a stored enable must leave the core running
      wb(1'b1, ADDR_CTRL, 32'h2, 4'h1);
      wb(1'b1, ADDR_CTRL, 32'h12, 4'h1);
      repeat (2) @(posedge clk);
      `CHK("goNoEnable", 1'b1, cpuRun)
      finish_test();
   end
endmodule : testbench
